// ==== hw/host_bus_port.sv ====
// strobe-timed parallel host port routing accesses to two uart channels
`timescale 1ns/100ps
module host_bus_port
   import host_port_pkg::*;
(
   input  wire logic               clk_i,            // 100 MHz clock
   input  wire logic               rst_n_i,          // async reset, low
   input  wire logic               chip_sel_n_i,     // chip select, low
   input  wire logic               channel_pick_i,   // 1 = A, 0 = B
   input  wire logic               read_strobe_n_i,  // read strobe, low
   input  wire logic               write_strobe_n_i, // write strobe, low
   input  wire logic [INDEX_W-1:0] reg_index_i,      // register index
   input  wire logic [DATA_W-1:0]  data_i,           // data bus in
   output logic      [DATA_W-1:0]  data_o,           // data bus out
   output logic                    data_oe_o,        // data bus enable
   input  wire logic               alt_bcast_i,      // alt function bit 0
   output reg_read_t               rd_req_o,         // read start pulse
   input  wire logic [DATA_W-1:0]  chan_a_rdata_i,   // channel A read data
   input  wire logic [DATA_W-1:0]  chan_b_rdata_i,   // channel B read data
   output reg_write_t              wr_req_o,         // write pulse
   input  wire logic               chan_a_pend_i,    // channel A pending
   input  wire logic               chan_b_pend_i,    // channel B pending
   input  wire logic               chan_a_tx_room_i, // channel A tx room
   input  wire logic               chan_b_tx_room_i, // channel B tx room
   output logic                    chan_a_irq_o,     // channel A irq
   output logic                    chan_b_irq_o,     // channel B irq
   output logic                    chan_a_tx_ready_n_o, // A tx ready, low
   output logic                    chan_b_tx_ready_n_o  // B tx ready, low
);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   // bit layout: cs_n, pick, rd_n, wr_n, index, data
   localparam int PIN_W = 4 + INDEX_W + DATA_W;
   typedef logic [PIN_W-1:0] pins_t;

   pins_t sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
   logic  rd_n_d_ff, wr_n_d_ff, nxt_rd_n_d, nxt_wr_n_d;

   always_comb begin
      nxt_sync1 = {chip_sel_n_i, channel_pick_i, read_strobe_n_i,
                   write_strobe_n_i, reg_index_i, data_i};
      nxt_sync2 = sync1_ff;
      nxt_rd_n_d = sync2_ff[PIN_W-3];
      nxt_wr_n_d = sync2_ff[PIN_W-4];
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_ff  <= '1;
         sync2_ff  <= '1;
         rd_n_d_ff <= 1'h1;
         wr_n_d_ff <= 1'h1;
      end else begin
         sync1_ff  <= nxt_sync1;
         sync2_ff  <= nxt_sync2;
         rd_n_d_ff <= nxt_rd_n_d;
         wr_n_d_ff <= nxt_wr_n_d;
      end
   end

   logic               cs_n_s, pick_s, rd_n_s, wr_n_s;
   logic [INDEX_W-1:0] index_s;
   logic [DATA_W-1:0]  data_s;
   assign {cs_n_s, pick_s, rd_n_s, wr_n_s, index_s, data_s} = sync2_ff;

   // ------------------------------------------------------------------
   // strobe edges and channel routing
   // ------------------------------------------------------------------
   // which channels an access reaches; bit 0 is channel A, bit 1 channel B.
   // broadcast only ever widens a selected access, never one without cs
   function automatic logic [1:0] route(input logic cs_n,
                                        input logic pick,
                                        input logic bcast);
      logic [1:0] hit;
      hit = 2'h0;
      if (!cs_n) begin
         hit[0] = (pick == PICK_A) | bcast;             // [R4] [R5]
         hit[1] = (pick != PICK_A) | bcast;             // [R4] [R5]
      end
      return hit;
   endfunction

   logic rd_fall, wr_rise;
   assign rd_fall = rd_n_d_ff & ~rd_n_s;
   assign wr_rise = ~wr_n_d_ff & wr_n_s;

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   // the phase remembers which channel feeds the byte while the strobe
   // stays low, so a register that changes mid-strobe is still reflected
   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_CH_A = 3'b010,
      RD_CH_B = 3'b100
   } rd_phase_t;

   reg_read_t         rd_ff, nxt_rd;
   rd_phase_t         rd_phase_ff, nxt_rd_phase;
   logic [1:0]        rd_hit;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_rd       = '0;
      nxt_rd_phase = rd_phase_ff;
      rd_hit       = route(cs_n_s, pick_s, 1'h0);
      // reads never broadcast: one byte can only come from one channel
      if (rd_fall && (rd_hit != 2'h0)) begin
         nxt_rd.rd_a  = rd_hit[0];                      // [R1] [R5]
         nxt_rd.rd_b  = rd_hit[1];                      // [R1] [R5]
         nxt_rd.index = index_s;                        // [R10]
         nxt_rd_phase = rd_hit[0] ? RD_CH_A : RD_CH_B;
      end else if (rd_n_s || cs_n_s) begin
         nxt_rd_phase = RD_IDLE;
      end
   end

   always_comb begin
      nxt_rdata = rdata_ff;
      unique case (rd_phase_ff)
         RD_IDLE: nxt_rdata = rdata_ff;
         RD_CH_A: nxt_rdata = chan_a_rdata_i;           // [R1]
         RD_CH_B: nxt_rdata = chan_b_rdata_i;           // [R1]
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_ff       <= '0;
         rd_phase_ff <= RD_IDLE;
         rdata_ff    <= '0;
      end else begin
         rd_ff       <= nxt_rd;
         rd_phase_ff <= nxt_rd_phase;
         rdata_ff    <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------------
   // write path
   // ------------------------------------------------------------------
   // data taken at the rising edge; cs must still be low there, so a
   // select that drops before the strobe cancels the write
   reg_write_t wr_ff, nxt_wr;
   logic [1:0] wr_hit;

   always_comb begin
      nxt_wr = '0;
      wr_hit = route(cs_n_s, pick_s, alt_bcast_i);      // [R6]
      if (wr_rise && (wr_hit != 2'h0)) begin
         nxt_wr.wr_a  = wr_hit[0];                      // [R3] [R6]
         nxt_wr.wr_b  = wr_hit[1];                      // [R3] [R6]
         nxt_wr.index = index_s;                        // [R10]
         nxt_wr.data  = data_s;                         // [R3] [R9]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
      end
   end

   assign rd_req_o  = rd_ff;
   assign wr_req_o  = wr_ff;
   assign data_o    = rdata_ff;                           // [R9]
   // enable from raw pins: sync delay would drive past the strobe end
   assign data_oe_o = ~chip_sel_n_i & ~read_strobe_n_i;   // [R11]

   // ------------------------------------------------------------------
   // per-channel status outputs
   // ------------------------------------------------------------------
   logic [1:0] irq_ff, nxt_irq, txr_n_ff, nxt_txr_n;

   always_comb begin
      nxt_irq   = {chan_b_pend_i, chan_a_pend_i};          // [R7]
      nxt_txr_n = ~{chan_b_tx_room_i, chan_a_tx_room_i};   // [R8]
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_ff   <= 2'h0;
         txr_n_ff <= 2'h3;
      end else begin
         irq_ff   <= nxt_irq;
         txr_n_ff <= nxt_txr_n;
      end
   end

   assign chan_a_irq_o        = irq_ff[0];
   assign chan_b_irq_o        = irq_ff[1];
   assign chan_a_tx_ready_n_o = txr_n_ff[0];
   assign chan_b_tx_ready_n_o = txr_n_ff[1];

endmodule

// ==== hw/host_port_pkg.sv ====
// constants and carrier types of the dual-channel host bus port
// What this block does
// R1: read strobe fall starts a read of the indexed register; byte driven out.
// R2: host captures read data at the read strobe rising edge.
// R3: write strobe fall starts a write; byte loaded at its rising edge.
// R4: transfers happen only while chip select is asserted.
// R5: channel pick low routes to channel B, high to channel A.
// R6: alternate function bit 0 makes writes reach both channels.
// R7: each channel irq output is high while that channel requests service.
// R8: each channel has an active-low transmitter-ready output from its tx state.
// R9: data bus is eight bits wide and bidirectional.
// R10: three index lines select one register of the addressed channel.
// R11: data bus driven only while chip select and read strobe are asserted.
package host_port_pkg;
   localparam int DATA_W  = 8;
   localparam int INDEX_W = 3;
   // index of the alternate function register; its bit 0 is the broadcast
   localparam logic [INDEX_W-1:0] ALT_FUNC_INDEX = 3'h2;
   localparam int BCAST_BIT = 0;
   localparam logic PICK_A = 1'h1;

   // one access handed to a channel's register file
   typedef struct packed {
      logic               wr_a;
      logic               wr_b;
      logic [INDEX_W-1:0] index;
      logic [DATA_W-1:0]  data;
   } reg_write_t;

   typedef struct packed {
      logic               rd_a;
      logic               rd_b;
      logic [INDEX_W-1:0] index;
   } reg_read_t;
endpackage

// ==== test/chan_regs_model.sv ====
// register files of both channels answering the port's pulses
`timescale 1ns/100ps
module chan_regs_model
   import host_port_pkg::*;
(
   input  wire logic         clk_i,    // clock
   input  wire reg_read_t    rd_req_i, // read pulse
   input  wire reg_write_t   wr_req_i, // write pulse
   output logic [DATA_W-1:0] a_rd_o,   // channel A byte
   output logic [DATA_W-1:0] b_rd_o    // channel B byte
);
   logic [DATA_W-1:0]  mem [2][8];
   logic [INDEX_W-1:0] idx_ff = '0;
   wire                rd = rd_req_i.rd_a | rd_req_i.rd_b;
   initial for (int i = 0; i < 8; i++) begin
      mem[0][i] = 8'ha0 + 8'(i);
      mem[1][i] = 8'hb0 + 8'(i);
   end
   always @(posedge clk_i) begin
      if (rd) idx_ff <= rd_req_i.index;
      if (wr_req_i.wr_a) mem[0][wr_req_i.index] <= wr_req_i.data;
      if (wr_req_i.wr_b) mem[1][wr_req_i.index] <= wr_req_i.data;
   end
   // index held after the pulse, data_o keeps refreshing from it
   assign a_rd_o = mem[0][rd ? rd_req_i.index : idx_ff];
   assign b_rd_o = mem[1][rd ? rd_req_i.index : idx_ff];
endmodule

// ==== test/host_bus_port_properties.sv ====
// pin-level checks of the host bus port
`timescale 1ns/100ps
module host_bus_port_properties
   import host_port_pkg::*;
(
   input wire logic clk_i, rst_n_i, chip_sel_n_i, channel_pick_i,
   input wire logic read_strobe_n_i, data_oe_o, alt_bcast_i,
   input wire logic chan_a_pend_i, chan_b_pend_i, chan_a_irq_o,
   input wire logic chan_b_irq_o, chan_a_tx_room_i, chan_b_tx_room_i,
   input wire logic chan_a_tx_ready_n_o, chan_b_tx_ready_n_o,
   input wire logic [DATA_W-1:0] data_i,
   input wire reg_read_t rd_req_o,
   input wire reg_write_t wr_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire rd = rd_req_o.rd_a | rd_req_o.rd_b;
   wire wr = wr_req_o.wr_a | wr_req_o.wr_b;
   sequence rd_start; $fell(read_strobe_n_i) && !chip_sel_n_i; endsequence
   sequence rd_pulse; rd ##1 !rd; endsequence
   a_read_start: assert property (rd_start |-> ##[1:4] rd_pulse)
      else $error("no read pulse");
   a_oe_window: assert property (data_oe_o == (!chip_sel_n_i &&
      !read_strobe_n_i)) else $error("bad bus enable");
   a_read_cs: assert property (rd |-> !$past(chip_sel_n_i, 3))
      else $error("read without select");
   a_pick_route: assert property (rd |-> rd_req_o.rd_a ==
      $past(channel_pick_i, 3) && rd_req_o.rd_b != $past(channel_pick_i, 3))
      else $error("bad channel");
   a_bcast_both: assert property (wr && $past(alt_bcast_i) |->
      wr_req_o.wr_a && wr_req_o.wr_b) else $error("broadcast missed");
   a_wr_data: assert property (wr |-> wr_req_o.data == $past(data_i, 3))
      else $error("bad write byte");
   a_irq_follow: assert property ($past(rst_n_i) |->
      chan_a_irq_o == $past(chan_a_pend_i) &&
      chan_b_irq_o == $past(chan_b_pend_i)) else $error("bad irq");
   a_txrdy_follow: assert property ($past(rst_n_i) |->
      chan_a_tx_ready_n_o == !$past(chan_a_tx_room_i) &&
      chan_b_tx_ready_n_o == !$past(chan_b_tx_room_i)) else $error("bad txrdy");
endmodule
bind host_bus_port host_bus_port_properties chk (.clk_i, .rst_n_i,
   .chip_sel_n_i, .channel_pick_i, .read_strobe_n_i, .data_oe_o,
   .alt_bcast_i, .chan_a_pend_i, .chan_b_pend_i, .chan_a_irq_o,
   .chan_b_irq_o, .chan_a_tx_room_i, .chan_b_tx_room_i,
   .chan_a_tx_ready_n_o, .chan_b_tx_ready_n_o, .data_i, .rd_req_o,
   .wr_req_o);

// ==== test/testbench.sv ====
// self-checking bench of the host bus port
`timescale 1ns/100ps
module testbench
   import host_port_pkg::*;
;
   logic clk_i = 0, rst_n_i = 0, cs_n = 1, pk = 0, rd_n = 1, wr_n = 1;
   logic bc = 0, pa = 0, pb = 0, ra = 0, rb = 0, oe, ia, ib, ta, tb;
   logic [2:0] ix = '0;
   logic [7:0] din = '0, dout, ard, brd, mir [2][8];
   logic [31:0] rv;
   reg_read_t rq;
   reg_write_t wq;
   int num_errors = 0, tests_run = 0;
   always #5 clk_i = ~clk_i;
   host_bus_port dut (.clk_i, .rst_n_i, .chip_sel_n_i(cs_n),
      .channel_pick_i(pk), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
      .reg_index_i(ix), .data_i(din), .data_o(dout), .data_oe_o(oe),
      .alt_bcast_i(bc), .rd_req_o(rq), .chan_a_rdata_i(ard),
      .chan_b_rdata_i(brd), .wr_req_o(wq), .chan_a_pend_i(pa),
      .chan_b_pend_i(pb), .chan_a_tx_room_i(ra), .chan_b_tx_room_i(rb),
      .chan_a_irq_o(ia), .chan_b_irq_o(ib), .chan_a_tx_ready_n_o(ta),
      .chan_b_tx_ready_n_o(tb));
   chan_regs_model far (.clk_i, .rd_req_i(rq), .wr_req_i(wq), .a_rd_o(ard),
      .b_rd_o(brd));
   task automatic check(string what, logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // bounded wait for the read or write pulse
   task automatic wait_pulse(input bit w);
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         #1;
         if (w ? (wq.wr_a | wq.wr_b) : (rq.rd_a | rq.rd_b)) break;
      end
      if (n == 20) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic access(input bit w, logic p, logic [2:0] i, logic [7:0] d);
      @(negedge clk_i);
      {cs_n, pk, ix, din} = {1'b0, p, i, d};
      if (w) wr_n = 0;
      else rd_n = 0;
      #1 check("oe", 8'(oe), 8'(!w));
      if (w) begin
         repeat (4) @(negedge clk_i);
         wr_n = 1;
      end
      wait_pulse(w);
      if (w) begin
         check("wr_ch", 8'({wq.wr_a, wq.wr_b}), 8'({bc | p, bc | !p}));
         check("wr_byte", wq.data, d);
         check("wr_index", 8'(wq.index), 8'(i));
         if (bc | p) mir[0][i] = d;
         if (bc | !p) mir[1][i] = d;
      end else begin
         check("rd_ch", 8'({rq.rd_a, rq.rd_b}), 8'({p, !p}));
         check("rd_index", 8'(rq.index), 8'(i));
         repeat (3) @(posedge clk_i);
         #1 check("rd_byte", dout, mir[!p][i]);
      end
      @(negedge clk_i);
      if (!w) check("rd_at_rise", dout, mir[!p][i]);
      {cs_n, rd_n} = 2'b11;
      #1 check("oe_off", 8'(oe), 8'h00);
      repeat (4) @(negedge clk_i);
   endtask
   initial begin
      rv = $urandom(9793);
      for (int i = 0; i < 8; i++) {mir[0][i], mir[1][i]} = {8'ha0 + 8'(i),
         8'hb0 + 8'(i)};
      repeat (20) @(negedge clk_i);
      check("rst", 8'({ia, ib, ta, tb}), 8'h03);
      check("rst_data", dout, 8'h00);
      rst_n_i = 1;
      repeat (4) @(negedge clk_i);
      access(0, 1, 7, 0);
      access(0, 0, 0, 0);
      access(1, 1, 0, 8'h5a);
      access(0, 1, 0, 0);
      bc = 1;
      access(1, 0, ALT_FUNC_INDEX, 8'hc3);
      access(0, 1, ALT_FUNC_INDEX, 0);
      for (int k = 0; k < 24; k++) begin
         rv = $urandom;
         bc = rv[13];
         access(rv[0], rv[1], rv[4:2], rv[12:5]);
      end
      {cs_n, wr_n} = 2'b10;
      repeat (4) @(negedge clk_i);
      wr_n = 1;
      rv = 0;
      repeat (8) begin
         @(posedge clk_i);
         #1 rv[0] |= wq.wr_a | wq.wr_b;
      end
      check("no_write", rv[7:0], 8'h00);
      repeat (20) begin
         @(negedge clk_i);
         {pa, pb, ra, rb} = 4'($urandom);
         @(posedge clk_i);
         #1 check("status", 8'({ia, ib, ta, tb}), 8'({pa, pb, ~ra, ~rb}));
      end
      tally_and_finish();
   end
endmodule
